// ==== pnf_pkg.sv ====
// Constants, register layout and codes for the RGB panel output formatter
package pnf_pkg;
  // ----------------------------------------
  // Register offsets (16-bit registers)
  // ----------------------------------------
  localparam logic [11:0] PANEL_CFG_OFS = 12'h800;
  localparam logic [11:0] SCMD_CFG_OFS = 12'h816;
  localparam logic [11:0] CMD_LO_OFS = 12'h818;
  localparam logic [11:0] CMD_HI_OFS = 12'h81a;
  localparam logic [15:0] PANEL_CFG_RST = 16'h0000;
  localparam logic [15:0] SCMD_CFG_RST = 16'h0000;
  localparam logic [15:0] CMD_RST = 16'h0000;
  // ----------------------------------------
  // Field positions and codes
  // ----------------------------------------
  localparam int PCFG_NOT_RGB_BIT = 14;
  localparam int PCFG_TYPE_LSB = 0;
  localparam int PCFG_BUS_LSB = 8;
  localparam logic [2:0] TYPE_RGB = 3'h0;
  localparam logic [2:0] BUS_16 = 3'h1;
  localparam logic [2:0] BUS_18 = 3'h2;
  localparam int SCFG_CPOL_BIT = 0;
  localparam int SCFG_CPHA_BIT = 1;
  localparam int SCFG_LSBF_BIT = 2;
  localparam int SCFG_SPORT_BIT = 3;
  localparam int SCFG_VAR_LSB = 5;
  localparam logic [2:0] VAR_4PIN = 3'h0;
  localparam logic [2:0] VAR_3PIN = 3'h1;
  localparam logic [2:0] VAR_ASI = 3'h2;
  localparam logic [2:0] VAR_UWIRE = 3'h4;
  localparam logic [2:0] VAR_SER24 = 3'h5;
  localparam int CMDHI_DC_BIT = 8;
  localparam int STAT_BUSY_BIT = 15;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int SCLK_HALF_CYC = 2;

  // Frame length in bits per variant, zero where the code is unused
  function automatic logic [4:0] var_len(input logic [2:0] v);
    unique case (v)
      VAR_4PIN: var_len = 5'h08;
      VAR_3PIN: var_len = 5'h09;
      VAR_ASI: var_len = 5'h10;
      VAR_UWIRE: var_len = 5'h10;
      VAR_SER24: var_len = 5'h18;
      default: var_len = 5'h00;
    endcase
  endfunction
endpackage

// ==== pnf_sync.sv ====
// Two-flop level synchroniser
`timescale 1ns/1ps
module pnf_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Level in and out
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_q <= '0;
      o_q <= '0;
    end else begin
      meta_q <= i_d;
      o_q <= meta_q;
    end
  end
endmodule

// ==== pnf_sershift.sv ====
// Serial command shifter with selectable polarity, phase and bit order
`timescale 1ns/1ps
module pnf_sershift #(
  parameter int DW = 24,
  parameter int HALF = pnf_pkg::SCLK_HALF_CYC
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Request
  input wire logic i_start,
  input wire logic [DW-1:0] i_data,
  input wire logic [4:0] i_len,
  input wire logic i_dc,
  input wire logic i_cpol,
  input wire logic i_cpha,
  input wire logic i_lsbf,
  // Line
  output logic o_busy,
  output logic o_cs_n,
  output logic o_sclk,
  output logic o_dc,
  output logic o_sdo
);
  typedef enum logic [1:0] {IDLE, SHIFT, GAP} pnf_sst_t;
  pnf_sst_t st_q;
  logic [DW-1:0] sr_q;
  logic [7:0] hc_q;
  logic [4:0] bc_q;
  logic ph_q;
  logic cpol_q, cpha_q, lsbf_q;
  logic half_end;

  assign half_end = (hc_q == 8'(HALF - 1));

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_q <= IDLE;
      sr_q <= '0;
      hc_q <= '0;
      bc_q <= '0;
      ph_q <= 1'b0;
      cpol_q <= 1'b0;
      cpha_q <= 1'b0;
      lsbf_q <= 1'b0;
    end else begin
      hc_q <= half_end ? 8'h00 : hc_q + 8'h01;
      unique case (st_q)
        IDLE: begin
          hc_q <= 8'h00;
          ph_q <= 1'b0;
          if (i_start) begin
            st_q <= SHIFT;
            // Left-justify so MSB-first always leaves from the top bit
            sr_q <= i_lsbf ? i_data : i_data << (DW - int'(i_len));
            bc_q <= i_len - 5'h01;
            cpol_q <= i_cpol;
            cpha_q <= i_cpha;
            lsbf_q <= i_lsbf;
          end
        end
        SHIFT: if (half_end) begin
          ph_q <= ~ph_q;
          if (ph_q) begin
            sr_q <= lsbf_q ? sr_q >> 1 : sr_q << 1;
            bc_q <= bc_q - 5'h01;
            if (bc_q == 5'h00) st_q <= GAP;
          end
        end
        GAP: if (half_end) begin
          ph_q <= ~ph_q;
          if (ph_q) st_q <= IDLE;
        end
        default: st_q <= IDLE;
      endcase
    end
  end

  // Chip select stays high one full clock period after each frame
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_cs_n <= 1'b1;
      o_sclk <= 1'b0;
      o_sdo <= 1'b0;
      o_dc <= 1'b0;
      o_busy <= 1'b0;
    end else begin
      o_busy <= (st_q != IDLE) || i_start;
      o_cs_n <= (st_q != SHIFT);
      o_sclk <= (st_q == SHIFT) ? (cpol_q ^ (cpha_q ? ~ph_q : ph_q)) : cpol_q;
      o_sdo <= (st_q == SHIFT) ? (lsbf_q ? sr_q[0] : sr_q[DW-1]) : 1'b0;
      if (i_start && st_q == IDLE) o_dc <= i_dc;
    end
  end
endmodule

// ==== pnf_top.sv ====
// RGB panel output formatter: pixel packing, config registers, aux pin mux
// ----------------------------------------
// How it works
// RQ1: RGB mode needs bit14 clear, type 000b
// RQ2: Width code 001b gives 16-bit 5:6:5 output
// RQ3: Width code 010b gives 18-bit 6:6:6 output
// RQ4: 16-bit pin order, pins 11, 17 low
// RQ5: 18-bit pin order, all eighteen pins used
// RQ6: Variant field at serial config bits 7-5
// RQ7: Serial-command RGB panel owns aux pins 3-0
// RQ8: Variant 000b: select, clock, cmd/data, data
// RQ9: Variant 001b: select, clock, data; pin2 unused
// RQ10: Variant 010b: strobe, clock, data; pin2 unused
// RQ11: Variant 100b: chip select, clock, data
// RQ12: Variant 101b: select, clock, data; pin2 unused
// RQ13: General TFT leaves aux pins unassigned
// RQ14: Bit order, phase and polarity are programmable
// RQ15: Pixels arrive from the SDRAM frame store
// RQ16: Host keeps select high one clock between
// ----------------------------------------
`timescale 1ns/1ps
module pnf_top #(
  parameter int CMD_W = 24,
  parameter int SCLK_HALF = pnf_pkg::SCLK_HALF_CYC
) (
  // Clocks and reset
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_pclk,
  // Register port
  input wire logic [11:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [15:0] i_reg_wdata,
  output logic [15:0] o_reg_rdata,
  // Pixel stream from the frame store, pixel clock domain
  input wire logic i_pix_valid,
  input wire logic [5:0] i_pix_r,
  input wire logic [5:0] i_pix_g,
  input wire logic [5:0] i_pix_b,
  // Panel data
  output logic [17:0] o_panel_data_pin,
  output logic o_panel_de,
  // Auxiliary pin group
  output logic [3:0] o_aux_pin_group,
  output logic [3:0] o_aux_oe
);
  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  logic [15:0] panel_type_config_q;
  logic [15:0] serial_cmd_config_q;
  logic [15:0] cmd_lo_q;
  logic [8:0] cmd_hi_q;
  logic rgb_mode, w16, w18, sport_en, start_ok;
  logic [2:0] variant;
  logic [4:0] frame_len;
  logic sh_busy, sh_cs_n, sh_sclk, sh_dc, sh_sdo;
  logic start_q;
  logic [CMD_W-1:0] sh_data;

  assign rgb_mode = !panel_type_config_q[pnf_pkg::PCFG_NOT_RGB_BIT] &&
                    (panel_type_config_q[pnf_pkg::PCFG_TYPE_LSB +: 3] == pnf_pkg::TYPE_RGB); // RQ1
  assign w16 = rgb_mode && (panel_type_config_q[pnf_pkg::PCFG_BUS_LSB +: 3] == pnf_pkg::BUS_16); // RQ2
  assign w18 = rgb_mode && (panel_type_config_q[pnf_pkg::PCFG_BUS_LSB +: 3] == pnf_pkg::BUS_18); // RQ3
  assign variant = serial_cmd_config_q[pnf_pkg::SCFG_VAR_LSB +: 3]; // RQ6
  assign frame_len = pnf_pkg::var_len(variant);
  // General TFT (port disabled) never claims the aux pins
  assign sport_en = rgb_mode && serial_cmd_config_q[pnf_pkg::SCFG_SPORT_BIT] && (frame_len != 5'h00); // RQ7 RQ13
  assign start_ok = i_reg_wr && (i_reg_addr == pnf_pkg::CMD_HI_OFS) && sport_en && !sh_busy;

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      panel_type_config_q <= pnf_pkg::PANEL_CFG_RST;
      serial_cmd_config_q <= pnf_pkg::SCMD_CFG_RST;
      cmd_lo_q <= pnf_pkg::CMD_RST;
      cmd_hi_q <= '0;
    end else if (i_reg_wr) begin
      unique case (i_reg_addr)
        pnf_pkg::PANEL_CFG_OFS: panel_type_config_q <= i_reg_wdata;
        pnf_pkg::SCMD_CFG_OFS: serial_cmd_config_q <= i_reg_wdata;
        pnf_pkg::CMD_LO_OFS: cmd_lo_q <= i_reg_wdata;
        pnf_pkg::CMD_HI_OFS: cmd_hi_q <= i_reg_wdata[8:0];
        default: ;
      endcase
    end
  end

  // Read data is captured on the read strobe; unmapped offsets read zero
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_reg_rdata <= '0;
    end else if (i_reg_rd) begin
      unique case (i_reg_addr)
        pnf_pkg::PANEL_CFG_OFS: o_reg_rdata <= panel_type_config_q;
        pnf_pkg::SCMD_CFG_OFS: o_reg_rdata <= serial_cmd_config_q;
        pnf_pkg::CMD_LO_OFS: o_reg_rdata <= cmd_lo_q;
        pnf_pkg::CMD_HI_OFS: o_reg_rdata <= {sh_busy, 6'h00, cmd_hi_q};
        default: o_reg_rdata <= '0;
      endcase
    end
  end

  // ----------------------------------------
  // Serial command engine
  // ----------------------------------------
  // The 9-bit variant carries the cmd/data flag as bit 8, its first bit when sent MSB-first
  always_comb begin
    sh_data = {i_reg_wdata[7:0], cmd_lo_q};
    if (variant == pnf_pkg::VAR_3PIN) begin
      sh_data = {15'h0000, i_reg_wdata[pnf_pkg::CMDHI_DC_BIT], cmd_lo_q[7:0]};
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      start_q <= 1'b0;
    end else begin
      start_q <= start_ok;
    end
  end

  pnf_sershift #(
    .DW(CMD_W),
    .HALF(SCLK_HALF)
  ) u_shift (
    .i_clk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_start(start_ok),
    .i_data(sh_data),
    .i_len(frame_len),
    .i_dc(i_reg_wdata[pnf_pkg::CMDHI_DC_BIT]),
    .i_cpol(serial_cmd_config_q[pnf_pkg::SCFG_CPOL_BIT]), // RQ14
    .i_cpha(serial_cmd_config_q[pnf_pkg::SCFG_CPHA_BIT]), // RQ14
    .i_lsbf(serial_cmd_config_q[pnf_pkg::SCFG_LSBF_BIT]), // RQ14
    .o_busy(sh_busy),
    .o_cs_n(sh_cs_n),
    .o_sclk(sh_sclk),
    .o_dc(sh_dc),
    .o_sdo(sh_sdo)
  );

  // ----------------------------------------
  // Aux pin assignment per variant
  // ----------------------------------------
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_aux_pin_group <= 4'h0;
      o_aux_oe <= 4'h0;
    end else if (!sport_en) begin
      o_aux_pin_group <= 4'h0; // RQ13
      o_aux_oe <= 4'h0; // RQ13
    end else begin
      o_aux_pin_group[1] <= sh_sclk;
      o_aux_pin_group[3] <= sh_sdo;
      o_aux_pin_group[2] <= 1'b0;
      o_aux_oe <= 4'hb;
      unique case (variant)
        pnf_pkg::VAR_4PIN: begin
          o_aux_pin_group[0] <= sh_cs_n; // RQ8
          o_aux_pin_group[2] <= sh_dc; // RQ8
          o_aux_oe <= 4'hf; // RQ8
        end
        pnf_pkg::VAR_3PIN: o_aux_pin_group[0] <= sh_cs_n; // RQ9
        pnf_pkg::VAR_ASI: o_aux_pin_group[0] <= ~sh_cs_n; // RQ10
        pnf_pkg::VAR_UWIRE: o_aux_pin_group[0] <= ~sh_cs_n; // RQ11
        pnf_pkg::VAR_SER24: o_aux_pin_group[0] <= sh_cs_n; // RQ12
        default: o_aux_pin_group[0] <= 1'b1;
      endcase
    end
  end

  // ----------------------------------------
  // Pixel clock domain
  // ----------------------------------------
  // Width settings are quasi-static, so a level crossing is enough;
  // a change mid-frame may show one mixed pixel.
  logic prst_b;
  logic [2:0] pmode;
  logic p_rgb, p_w16, p_w18;

  // A flop on the system clock feeds the synchroniser, so a decode
  // glitch during a register write never reaches the pixel side.
  logic [2:0] mode_q;

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mode_q <= 3'h0;
    end else begin
      mode_q <= {rgb_mode, w16, w18};
    end
  end

  pnf_sync #(
    .W(1)
  ) u_prst (
    .i_clk(i_pclk),
    .i_rst_b(i_rst_b),
    .i_d(1'b1),
    .o_q(prst_b)
  );

  pnf_sync #(
    .W(3)
  ) u_pmode (
    .i_clk(i_pclk),
    .i_rst_b(prst_b),
    .i_d(mode_q),
    .o_q(pmode)
  );

  assign p_rgb = pmode[2];
  assign p_w16 = pmode[1];
  assign p_w18 = pmode[0];

  // Stream from the SDRAM fetch path is packed straight onto the pins
  always_ff @(posedge i_pclk or negedge prst_b) begin
    if (!prst_b) begin
      o_panel_data_pin <= '0;
      o_panel_de <= 1'b0;
    end else begin
      o_panel_de <= i_pix_valid && p_rgb && (p_w16 || p_w18); // RQ15
      if (!i_pix_valid || !p_rgb) begin
        o_panel_data_pin <= '0; // RQ1
      end else if (p_w16) begin
        // Red and blue use their top five bits
        o_panel_data_pin <= {1'b0, i_pix_b[1], i_pix_b[2], i_pix_g[0], i_pix_g[1], i_pix_g[2],
                             1'b0, i_pix_r[1], i_pix_r[2], i_pix_b[3], i_pix_b[4], i_pix_b[5],
                             i_pix_g[3], i_pix_g[4], i_pix_g[5], i_pix_r[3], i_pix_r[4], i_pix_r[5]}; // RQ4
      end else if (p_w18) begin
        o_panel_data_pin <= {i_pix_b[0], i_pix_b[1], i_pix_b[2], i_pix_g[0], i_pix_g[1], i_pix_g[2],
                             i_pix_r[0], i_pix_r[1], i_pix_r[2], i_pix_b[3], i_pix_b[4], i_pix_b[5],
                             i_pix_g[3], i_pix_g[4], i_pix_g[5], i_pix_r[3], i_pix_r[4], i_pix_r[5]}; // RQ5
      end else begin
        o_panel_data_pin <= '0;
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Select-low time is counted so a frame one bit short or long is caught
  logic [7:0] low_q;
  logic [4:0] len_q;

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      low_q <= 8'h00;
    end else begin
      low_q <= sh_cs_n ? 8'h00 : low_q + 8'h01;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      len_q <= 5'h00;
    end else if (start_ok) begin
      len_q <= frame_len;
    end
  end

  pin_low16_a: assert property (@(posedge i_pclk) disable iff (!prst_b) // RQ4
    (p_rgb && p_w16) |=> (o_panel_data_pin[11] == 1'b0 && o_panel_data_pin[17] == 1'b0))
    else $error("16-bit pins 11 or 17 not low");

  pin_map18_a: assert property (@(posedge i_pclk) disable iff (!prst_b) // RQ5
    (i_pix_valid && p_rgb && p_w18) |=>
    (o_panel_data_pin[0] == $past(i_pix_r[5]) && o_panel_data_pin[17] == $past(i_pix_b[0])))
    else $error("18-bit pin order wrong");

  pin_map16_a: assert property (@(posedge i_pclk) disable iff (!prst_b) // RQ4
    (i_pix_valid && p_rgb && p_w16) |=>
    (o_panel_data_pin[10] == $past(i_pix_r[1]) && o_panel_data_pin[16] == $past(i_pix_b[1])))
    else $error("16-bit pin order wrong");

  not_rgb_a: assert property (@(posedge i_pclk) disable iff (!prst_b) // RQ1
    !p_rgb |=> (o_panel_data_pin == 18'h00000 && !o_panel_de))
    else $error("panel driven outside RGB mode");

  general_tft_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // RQ13
    !sport_en |=> (o_aux_oe == 4'h0))
    else $error("aux pins claimed without serial port");

  four_pin_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // RQ8
    (sport_en && variant == pnf_pkg::VAR_4PIN) |=> (o_aux_oe == 4'hf && o_aux_pin_group[2] == $past(sh_dc)))
    else $error("4-pin mapping wrong");

  pin2_unused_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // RQ9 RQ10 RQ11 RQ12
    (sport_en && variant != pnf_pkg::VAR_4PIN) |=> (o_aux_oe == 4'hb && !o_aux_pin_group[2]))
    else $error("pin 2 driven in variant without it");

  start_busy_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // RQ7
    start_q |-> sh_busy ##1 (!sh_cs_n)[*2])
    else $error("frame did not start after command write");

  cs_gap_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // RQ16
    $rose(sh_cs_n) |-> sh_cs_n[*4])
    else $error("select gap shorter than one clock period");

  cfg_write_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // RQ6
    (i_reg_wr && i_reg_addr == pnf_pkg::SCMD_CFG_OFS) |=> (variant == $past(i_reg_wdata[7:5])))
    else $error("variant field not updated");

  frame_len_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // RQ7
    $rose(sh_cs_n) |-> (low_q == 8'(len_q) * 8'(2 * SCLK_HALF)))
    else $error("frame length does not match variant");

  de_valid_a: assert property (@(posedge i_pclk) disable iff (!prst_b) // RQ15
    (i_pix_valid && p_rgb && (p_w16 || p_w18)) |=> o_panel_de)
    else $error("valid pixel not flagged");

  no_width_a: assert property (@(posedge i_pclk) disable iff (!prst_b) // RQ2 RQ3
    (p_rgb && !p_w16 && !p_w18) |=> (o_panel_data_pin == 18'h00000 && !o_panel_de))
    else $error("panel driven with no width selected");

  map_low_a: assert property (@(posedge i_pclk) disable iff (!prst_b) // RQ4 RQ5
    (i_pix_valid && p_rgb && (p_w16 || p_w18)) |=>
    (o_panel_data_pin[2] == $past(i_pix_r[3]) && o_panel_data_pin[3] == $past(i_pix_g[5]) &&
     o_panel_data_pin[6] == $past(i_pix_b[5])))
    else $error("shared low pins misplaced");

  sel_low_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // RQ8 RQ9 RQ12
    (sport_en && (variant == pnf_pkg::VAR_4PIN || variant == pnf_pkg::VAR_3PIN ||
                  variant == pnf_pkg::VAR_SER24)) |=> (o_aux_pin_group[0] == $past(sh_cs_n)))
    else $error("active-low select wrong");

  sel_high_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // RQ10 RQ11
    (sport_en && (variant == pnf_pkg::VAR_ASI || variant == pnf_pkg::VAR_UWIRE))
    |=> (o_aux_pin_group[0] == !$past(sh_cs_n)))
    else $error("strobe or chip select wrong");

  line_pins_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // RQ7
    sport_en |=> (o_aux_pin_group[1] == $past(sh_sclk) && o_aux_pin_group[3] == $past(sh_sdo)))
    else $error("clock or data pin wrong");

  unused_zero_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // RQ13
    !sport_en |=> (o_aux_pin_group == 4'h0))
    else $error("aux pins driven without serial port");

  busy_read_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // RQ7
    (i_reg_rd && i_reg_addr == pnf_pkg::CMD_HI_OFS) |=> (o_reg_rdata[pnf_pkg::STAT_BUSY_BIT] == $past(sh_busy)))
    else $error("busy bit not reported");

  rdata_hold_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // RQ6
    !i_reg_rd |=> $stable(o_reg_rdata))
    else $error("read data changed without a read");
endmodule

// ==== pnf_panel_model.sv ====
// Panel-side model of the serial command port
`timescale 1ns/1ps
module pnf_panel_model (
  // Aux pins from the controller
  input wire logic [3:0] i_aux,
  input wire logic [3:0] i_aux_oe,
  // Panel strapping
  input wire logic i_cpol,
  input wire logic i_cpha,
  input wire logic i_sel_high,
  input wire logic i_clr,
  // Received frame
  output logic [23:0] o_word,
  output logic [4:0] o_count,
  output logic o_dc
);
  logic sel;

  // Select polarity depends on the variant the panel is built for
  assign sel = i_aux_oe[0] & (i_sel_high ? i_aux[0] : ~i_aux[0]);

  // Sample on the mid-bit edge, where data from the controller is stable
  always @(posedge i_clr or posedge i_aux[1] or negedge i_aux[1]) begin
    if (i_clr) begin
      o_word = 24'h000000;
      o_count = 5'h00;
      o_dc = 1'b0;
    end else if (sel && i_aux_oe[1] && (i_aux[1] == ~(i_cpol ^ i_cpha))) begin
      o_word = {o_word[22:0], i_aux[3]};
      o_count = o_count + 5'h01;
      o_dc = i_aux[2];
    end
  end
endmodule

// ==== tb.sv ====
// Self-checking bench for the RGB panel output formatter
`timescale 1ns/1ps
module tb;
  logic i_mclk = 1'b0;
  logic i_pclk = 1'b0;
  logic i_rst_b = 1'b0;
  logic [11:0] i_reg_addr = 12'h000;
  logic i_reg_wr = 1'b0;
  logic i_reg_rd = 1'b0;
  logic [15:0] i_reg_wdata = 16'h0000;
  logic i_pix_valid = 1'b0;
  logic [5:0] i_pix_r = 6'h00;
  logic [5:0] i_pix_g = 6'h00;
  logic [5:0] i_pix_b = 6'h00;
  logic [15:0] o_reg_rdata;
  logic [17:0] o_panel_data_pin;
  logic o_panel_de;
  logic [3:0] o_aux_pin_group;
  logic [3:0] o_aux_oe;
  logic cpol = 1'b0;
  logic cpha = 1'b0;
  logic sel_high = 1'b0;
  logic clr = 1'b0;
  logic [23:0] rx_word;
  logic [4:0] rx_count;
  logic rx_dc;
  int mismatches = 0;
  int comparisons = 0;

  always #25 i_mclk = ~i_mclk;
  always #62.5 i_pclk = ~i_pclk;

  pnf_top i_pnf_top (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_pclk(i_pclk), .i_reg_addr(i_reg_addr),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
    .i_pix_valid(i_pix_valid), .i_pix_r(i_pix_r), .i_pix_g(i_pix_g), .i_pix_b(i_pix_b),
    .o_panel_data_pin(o_panel_data_pin), .o_panel_de(o_panel_de), .o_aux_pin_group(o_aux_pin_group),
    .o_aux_oe(o_aux_oe));

  pnf_panel_model i_pnf_panel_model (.i_aux(o_aux_pin_group), .i_aux_oe(o_aux_oe), .i_cpol(cpol),
    .i_cpha(cpha), .i_sel_high(sel_high), .i_clr(clr), .o_word(rx_word), .o_count(rx_count), .o_dc(rx_dc));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic end_sim();
    if (mismatches == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_line(input logic [23:0] got, input logic [23:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [11:0] a, input logic [15:0] d);
    @(negedge i_mclk);
    i_reg_addr = a;
    i_reg_wdata = d;
    i_reg_wr = 1'b1;
    @(negedge i_mclk);
    i_reg_wr = 1'b0;
  endtask

  task automatic reg_rd(input logic [11:0] a, output logic [15:0] d);
    @(negedge i_mclk);
    i_reg_addr = a;
    i_reg_rd = 1'b1;
    @(negedge i_mclk);
    i_reg_rd = 1'b0;
    d = o_reg_rdata;
  endtask

  task automatic clear_rx();
    @(negedge i_mclk);
    clr = 1'b1;
    @(negedge i_mclk);
    clr = 1'b0;
  endtask

  // Config is quasi-static across the clock boundary, so give it time to land
  task automatic settle();
    repeat (8) @(negedge i_pclk);
  endtask

  function automatic logic [17:0] map(input logic [5:0] r, input logic [5:0] g, input logic [5:0] b,
    input logic w18);
    map = {b[0] & w18, b[1], b[2], g[0], g[1], g[2], r[0] & w18, r[1], r[2],
      b[3], b[4], b[5], g[3], g[4], g[5], r[3], r[4], r[5]};
  endfunction

  function automatic logic [23:0] rev(input logic [23:0] x, input int n);
    rev = 24'h000000;
    for (int k = 0; k < n; k++) begin
      rev[k] = x[n - 1 - k];
    end
  endfunction

  task automatic pix(input logic [5:0] r, input logic [5:0] g, input logic [5:0] b, input logic v,
    input logic [17:0] e, input logic de);
    @(negedge i_pclk);
    i_pix_valid = v;
    i_pix_r = r;
    i_pix_g = g;
    i_pix_b = b;
    @(negedge i_pclk);
    if (v) begin
      chk_line({6'h00, o_panel_data_pin}, {6'h00, e});
    end
    chk_line({23'h000000, o_panel_de}, {23'h000000, de});
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    logic [15:0] d;
    reg_rd(12'h800, d);
    chk_reg(d, pnf_pkg::PANEL_CFG_RST);
    reg_rd(12'h816, d);
    chk_reg(d, pnf_pkg::SCMD_CFG_RST);
    reg_wr(12'h816, 16'h00ab);
    reg_rd(12'h816, d);
    chk_reg(d, 16'h00ab);
    reg_wr(12'h804, 16'hffff);
    reg_rd(12'h804, d);
    chk_reg(d, 16'h0000);
  endtask

  task automatic t_pix();
    logic [15:0] bad [4] = '{16'h0300, 16'h0000, 16'h4200, 16'h0201};
    reg_wr(12'h800, 16'h0200);
    settle();
    pix(6'h35, 6'h1c, 6'h2b, 1'b1, map(6'h35, 6'h1c, 6'h2b, 1'b1), 1'b1);
    pix(6'h0a, 6'h23, 6'h14, 1'b1, map(6'h0a, 6'h23, 6'h14, 1'b1), 1'b1);
    pix(6'h3f, 6'h3f, 6'h3f, 1'b0, 18'h00000, 1'b0);
    reg_wr(12'h800, 16'h0100);
    settle();
    pix(6'h35, 6'h1c, 6'h2b, 1'b1, map(6'h35, 6'h1c, 6'h2b, 1'b0), 1'b1);
    pix(6'h0a, 6'h23, 6'h14, 1'b1, map(6'h0a, 6'h23, 6'h14, 1'b0), 1'b1);
    for (int i = 0; i < 4; i++) begin
      reg_wr(12'h800, bad[i]);
      settle();
      pix(6'h3f, 6'h3f, 6'h3f, 1'b1, 18'h00000, 1'b0);
    end
  endtask

  task automatic t_ser();
    logic [2:0] v;
    logic lsbf;
    logic [15:0] d;
    logic [23:0] e;
    int len;
    int n;
    reg_wr(12'h800, 16'h0200);
    for (int i = 0; i < 5; i++) begin
      case (i)
        0: v = pnf_pkg::VAR_4PIN;
        1: v = pnf_pkg::VAR_3PIN;
        2: v = pnf_pkg::VAR_ASI;
        3: v = pnf_pkg::VAR_UWIRE;
        default: v = pnf_pkg::VAR_SER24;
      endcase
      cpol = i[0];
      cpha = i[1];
      lsbf = (i == 2);
      sel_high = (v == pnf_pkg::VAR_ASI) || (v == pnf_pkg::VAR_UWIRE);
      reg_wr(12'h816, {8'h00, v, 2'b01, lsbf, cpha, cpol});
      clear_rx();
      reg_wr(12'h818, 16'ha5c3);
      reg_wr(12'h81a, 16'h0196);
      reg_rd(12'h81a, d);
      chk_reg(d & 16'h8000, 16'h8000);
      n = 0;
      while (d[15] !== 1'b0) begin
        n++;
        if (n > 500) begin
          mismatches++;
          return;
        end
        reg_rd(12'h81a, d);
      end
      case (v)
        pnf_pkg::VAR_4PIN: begin len = 8; e = 24'h0000c3; end
        pnf_pkg::VAR_3PIN: begin len = 9; e = 24'h0001c3; end
        pnf_pkg::VAR_SER24: begin len = 24; e = 24'h96a5c3; end
        default: begin len = 16; e = 24'h00a5c3; end
      endcase
      if (lsbf) begin
        e = rev(e, len);
      end
      chk_line(rx_word, e);
      chk_line({19'h00000, rx_count}, 24'(len));
      chk_line({20'h00000, o_aux_oe}, (v == pnf_pkg::VAR_4PIN) ? 24'h00000f : 24'h00000b);
      chk_line({22'h000000, o_aux_pin_group[1:0]}, {22'h000000, cpol, ~sel_high});
      chk_line({23'h000000, (v == 3'h0) ? rx_dc : o_aux_pin_group[2]}, {23'h000000, v == 3'h0});
    end
  endtask

  task automatic t_off();
    logic [15:0] cfg [3] = '{16'h0200, 16'h0200, 16'h4200};
    logic [15:0] ser [3] = '{16'h0000, 16'h0068, 16'h0008};
    for (int i = 0; i < 3; i++) begin
      reg_wr(12'h800, cfg[i]);
      reg_wr(12'h816, ser[i]);
      clear_rx();
      reg_wr(12'h81a, 16'h0196);
      repeat (200) @(negedge i_mclk);
      chk_line({20'h00000, o_aux_oe}, 24'h000000);
      chk_line({19'h00000, rx_count}, 24'h000000);
    end
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  // Reset spans two system clock edges; the pixel side resets asynchronously
  initial begin
    repeat (2) @(posedge i_mclk);
    @(negedge i_mclk);
    i_rst_b = 1'b1;
    t_regs();
    t_pix();
    t_ser();
    t_off();
    end_sim();
  end
endmodule
